// >>> include/fims_consts.svh
// Register offsets, field positions, reset values and sync depth of the fault interrupt block.
`ifndef FIMS_CONSTS_SVH
`define FIMS_CONSTS_SVH

// ==================================================================
// Register offsets
`define FIMS_OFS_MASK_ONE 8'h1E
`define FIMS_OFS_MASK_TWO 8'h1F
`define FIMS_OFS_MASK_STATE 8'h20

// ==================================================================
// Mask register one fields
`define FIMS_BIT_INPUT_VOLT 4
`define FIMS_BIT_AUX_RAIL 1
`define FIMS_BIT_THERMAL 0

// ==================================================================
// Mask register two fields
`define FIMS_BIT_SWITCH_OC 7
`define FIMS_BIT_TIMER 6
`define FIMS_BIT_HICCUP 5
`define FIMS_BIT_LIGHT_LOAD 4
`define FIMS_BIT_CONV_READY 3
`define FIMS_BIT_HIGH_IMP 2

// ==================================================================
// Mask and live state register fields
`define FIMS_BIT_BUS_ERROR 7
`define FIMS_BIT_IN_CC 6
`define FIMS_BIT_OUT_CC 5
`define FIMS_BIT_UNDER_V 4
`define FIMS_BIT_OVER_V 3

// ==================================================================
// Writable bit masks and reset values
`define FIMS_WMASK_ONE 8'h13
`define FIMS_WMASK_TWO 8'hFC
`define FIMS_RST_MASK_ONE 8'h00
`define FIMS_RST_MASK_TWO 8'h00
`define FIMS_RST_BUS_ERR 1'h0

// ==================================================================
// Synchroniser depth for inputs from other domains
`define FIMS_SYNC_STAGES 2

`endif

// >>> include/fims_pkg.sv
// Types shared by the fault interrupt block.
package fims_pkg;

  // ==================================================================
  // Power-on state code as reported in the live state field
  typedef enum logic [2:0] {
    FIMS_PWR_RESET = 3'h0,
    FIMS_PWR_SOFT_START = 3'h1,
    FIMS_PWR_REGULATING = 3'h2,
    FIMS_PWR_HICCUP = 3'h3,
    FIMS_PWR_LIGHT_LOAD_DIS = 3'h4
  } fims_power_state_e;

  typedef logic [7:0] fims_byte_t;

endpackage : fims_pkg

// >>> design/fims_sync.sv
// Bank of two-flop synchronisers for inputs from outside the clock domain.
`timescale 1ns/10ps
`include "fims_consts.svh"

module fims_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==================================================================
  // Synchroniser chains
  // The first stage is read only by the second stage, so a metastable
  // value never reaches combinational logic.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic [`FIMS_SYNC_STAGES-1:0] chain_q;
      logic [`FIMS_SYNC_STAGES-1:0] chain_d;
      always_comb begin
        chain_d = {chain_q[`FIMS_SYNC_STAGES-2:0], async_in[gi]};
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          chain_q <= '0;
        end else begin
          chain_q <= chain_d;
        end
      end
      assign sync_out[gi] = chain_q[`FIMS_SYNC_STAGES-1];
    end
  endgenerate

endmodule : fims_sync

// >>> design/fims_top.sv
// Fault and event interrupt masking with live converter state readback.
//
// Function
// - Input under/over-voltage drives interrupt low unless its mask bit is set.
// - Auxiliary rail overcurrent or undervoltage drives interrupt unless masked.
// - Thermal shutdown drives interrupt unless its mask bit is set.
// - Power switch overcurrent drives interrupt unless its mask bit is set.
// - Supervisory timer expiry drives interrupt unless its mask bit is set.
// - Hiccup state drives interrupt unless its mask bit is set.
// - Light-load disabled state drives interrupt unless its mask bit is set.
// - Rising edge of conversion ready drives interrupt unless masked.
// - Rising edge into high impedance drives interrupt unless masked.
// - Serial bus error drives interrupt unless its mask bit is set.
// - Status bit 6 shows live input current limiting.
// - Status bit 5 shows live output current regulation.
// - Status bits 4 and 3 show live under- and over-voltage, unlatched.
// - Three-bit power state field reports the converter power-on state code.
`timescale 1ns/10ps
`include "fims_consts.svh"

module fims_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access from the serial bus engine
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fault and event sources from analog and converter control
  input wire logic input_under_voltage,
  input wire logic input_over_voltage,
  input wire logic aux_regulator_rail_fault,
  input wire logic thermal_shutdown,
  input wire logic switch_overcurrent,
  input wire logic timer_expired,
  input wire logic conversion_ready,
  input wire logic high_impedance_state,
  input wire logic input_current_limited,
  input wire logic output_current_limited,
  input wire logic [2:0] power_state,
  // Bus error pulse from the serial bus engine, same clock
  input wire logic serial_bus_error,
  // Interrupt pin
  output logic fault_interrupt_out_n
);

  // ==================================================================
  // Input synchronisation
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  logic uv_s;
  logic ov_s;
  logic aux_s;
  logic tsd_s;
  logic swoc_s;
  logic tmr_s;
  logic conv_s;
  logic hiz_s;
  logic in_cc_s;
  logic out_cc_s;
  logic [2:0] pwr_s;

  assign raw_in = {power_state, output_current_limited, input_current_limited, high_impedance_state,
                   conversion_ready, timer_expired, switch_overcurrent, thermal_shutdown,
                   aux_regulator_rail_fault, input_over_voltage, input_under_voltage};

  // The power state bits are synchronised one by one; the converter
  // changes one code at a time, so a torn code lasts one cycle at most.
  fims_sync #(
    .WIDTH(NSYNC)
  ) i_fims_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign uv_s = sync_in[0];
  assign ov_s = sync_in[1];
  assign aux_s = sync_in[2];
  assign tsd_s = sync_in[3];
  assign swoc_s = sync_in[4];
  assign tmr_s = sync_in[5];
  assign conv_s = sync_in[6];
  assign hiz_s = sync_in[7];
  assign in_cc_s = sync_in[8];
  assign out_cc_s = sync_in[9];
  assign pwr_s = sync_in[12:10];

  // ==================================================================
  // Register state
  fims_pkg::fims_byte_t mask_one_q;
  fims_pkg::fims_byte_t mask_one_d;
  fims_pkg::fims_byte_t mask_two_q;
  fims_pkg::fims_byte_t mask_two_d;
  logic bus_err_mask_q;
  logic bus_err_mask_d;
  fims_pkg::fims_byte_t rdata_q;
  fims_pkg::fims_byte_t rdata_d;
  logic wr_one;
  logic wr_two;
  logic wr_state;
  logic rd_state;

  always_comb begin
    wr_one = 1'b0;
    wr_two = 1'b0;
    wr_state = 1'b0;
    if (reg_addr == `FIMS_OFS_MASK_ONE) begin
      wr_one = reg_wr_en;
    end else if (reg_addr == `FIMS_OFS_MASK_TWO) begin
      wr_two = reg_wr_en;
    end else if (reg_addr == `FIMS_OFS_MASK_STATE) begin
      wr_state = reg_wr_en;
    end
  end

  // A read and a write to the same register in one cycle return the old value,
  // because the read samples the register before the write edge lands.
  assign rd_state = reg_rd_en && (reg_addr == `FIMS_OFS_MASK_STATE);

  always_comb begin
    mask_one_d = mask_one_q;
    mask_two_d = mask_two_q;
    bus_err_mask_d = bus_err_mask_q;
    rdata_d = rdata_q;
    if (wr_one) begin
      mask_one_d = reg_wdata & `FIMS_WMASK_ONE;
    end
    if (wr_two) begin
      mask_two_d = reg_wdata & `FIMS_WMASK_TWO;
    end
    if (wr_state) begin
      bus_err_mask_d = reg_wdata[`FIMS_BIT_BUS_ERROR];
    end
    if (reg_rd_en) begin
      if (reg_addr == `FIMS_OFS_MASK_ONE) begin
        rdata_d = mask_one_q;
      end else if (reg_addr == `FIMS_OFS_MASK_TWO) begin
        rdata_d = mask_two_q;
      end else if (reg_addr == `FIMS_OFS_MASK_STATE) begin
        rdata_d = {bus_err_mask_q, in_cc_s, out_cc_s, uv_s, ov_s, pwr_s};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_one_q <= `FIMS_RST_MASK_ONE;
      mask_two_q <= `FIMS_RST_MASK_TWO;
      bus_err_mask_q <= `FIMS_RST_BUS_ERR;
      rdata_q <= 8'h00;
    end else begin
      mask_one_q <= mask_one_d;
      mask_two_q <= mask_two_d;
      bus_err_mask_q <= bus_err_mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==================================================================
  // Pending events and interrupt pin
  // Edge events and bus errors stay pending until the live state register
  // is read; a new event in the clearing cycle wins over the clear.
  logic conv_prev_q;
  logic hiz_prev_q;
  logic conv_pend_q;
  logic conv_pend_d;
  logic hiz_pend_q;
  logic hiz_pend_d;
  logic berr_pend_q;
  logic berr_pend_d;
  logic irq_n_q;
  logic irq_n_d;
  logic conv_rise;
  logic hiz_rise;
  logic hiccup_s;
  logic ll_s;
  logic any_src;

  assign conv_rise = conv_s && !conv_prev_q;
  assign hiz_rise = hiz_s && !hiz_prev_q;
  assign hiccup_s = (pwr_s == fims_pkg::FIMS_PWR_HICCUP);
  assign ll_s = (pwr_s == fims_pkg::FIMS_PWR_LIGHT_LOAD_DIS);

  always_comb begin
    conv_pend_d = (conv_pend_q && !rd_state) || conv_rise;
    hiz_pend_d = (hiz_pend_q && !rd_state) || hiz_rise;
    berr_pend_d = (berr_pend_q && !rd_state) || serial_bus_error;
    any_src = ((uv_s || ov_s) && !mask_one_q[`FIMS_BIT_INPUT_VOLT])
            || (aux_s && !mask_one_q[`FIMS_BIT_AUX_RAIL])
            || (tsd_s && !mask_one_q[`FIMS_BIT_THERMAL])
            || (swoc_s && !mask_two_q[`FIMS_BIT_SWITCH_OC])
            || (tmr_s && !mask_two_q[`FIMS_BIT_TIMER])
            || (hiccup_s && !mask_two_q[`FIMS_BIT_HICCUP])
            || (ll_s && !mask_two_q[`FIMS_BIT_LIGHT_LOAD])
            || (conv_pend_q && !mask_two_q[`FIMS_BIT_CONV_READY])
            || (hiz_pend_q && !mask_two_q[`FIMS_BIT_HIGH_IMP])
            || (berr_pend_q && !bus_err_mask_q);
    irq_n_d = !any_src;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_prev_q <= 1'b0;
      hiz_prev_q <= 1'b0;
      conv_pend_q <= 1'b0;
      hiz_pend_q <= 1'b0;
      berr_pend_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      conv_prev_q <= conv_s;
      hiz_prev_q <= hiz_s;
      conv_pend_q <= conv_pend_d;
      hiz_pend_q <= hiz_pend_d;
      berr_pend_q <= berr_pend_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign fault_interrupt_out_n = irq_n_q;

  // ==================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  input_volt_a: assert property ((uv_s || ov_s) && !mask_one_q[`FIMS_BIT_INPUT_VOLT] |=> !irq_n_q)
    else $error("input voltage fault did not pull interrupt low");
  aux_rail_a: assert property (aux_s && !mask_one_q[`FIMS_BIT_AUX_RAIL] |=> !irq_n_q)
    else $error("aux rail fault did not pull interrupt low");
  thermal_a: assert property (tsd_s && !mask_one_q[`FIMS_BIT_THERMAL] |=> !irq_n_q)
    else $error("thermal shutdown did not pull interrupt low");
  switch_oc_a: assert property (swoc_s && !mask_two_q[`FIMS_BIT_SWITCH_OC] |=> !irq_n_q)
    else $error("switch overcurrent did not pull interrupt low");
  timer_exp_a: assert property (tmr_s && !mask_two_q[`FIMS_BIT_TIMER] |=> !irq_n_q)
    else $error("timer expiry did not pull interrupt low");
  hiccup_irq_a: assert property (hiccup_s && !mask_two_q[`FIMS_BIT_HICCUP] |=> !irq_n_q)
    else $error("hiccup state did not pull interrupt low");
  light_load_a: assert property (ll_s && !mask_two_q[`FIMS_BIT_LIGHT_LOAD] |=> !irq_n_q)
    else $error("light load state did not pull interrupt low");
  conv_edge_a: assert property ($rose(conv_s) && !mask_two_q[`FIMS_BIT_CONV_READY] && !wr_two
                                |-> ##2 !irq_n_q)
    else $error("conversion ready edge did not pull interrupt low");
  hiz_edge_a: assert property ($rose(hiz_s) && !mask_two_q[`FIMS_BIT_HIGH_IMP] && !wr_two
                               |-> ##2 !irq_n_q)
    else $error("high impedance edge did not pull interrupt low");
  bus_err_a: assert property (serial_bus_error && !bus_err_mask_q && !wr_state |-> ##2 !irq_n_q)
    else $error("bus error did not pull interrupt low");
  pend_hold_a: assert property (berr_pend_q && !rd_state |=> berr_pend_q)
    else $error("pending bus error dropped without a status read");
  idle_release_a: assert property (!any_src |=> irq_n_q)
    else $error("interrupt low with no enabled source");
  live_state_a: assert property (rd_state |=> reg_rdata[6:0] == {$past(in_cc_s), $past(out_cc_s),
                                 $past(uv_s), $past(ov_s), $past(pwr_s)})
    else $error("live state readback mismatch");
  reserved_zero_a: assert property (reg_rd_en && reg_addr == `FIMS_OFS_MASK_ONE
                                    |=> (reg_rdata & ~`FIMS_WMASK_ONE) == 8'h00)
    else $error("reserved bits of mask one read nonzero");

  // Readback is compared with the values sampled in the strobe cycle, since
  // the live inputs may already have moved by the time the data is seen.
  out_cc_read_a: assert property (rd_state
                                  |=> reg_rdata[`FIMS_BIT_OUT_CC] == $past(out_cc_s))
    else $error("output current limit readback mismatch");
  volt_read_a: assert property (rd_state
                                |=> reg_rdata[4:3] == {$past(uv_s), $past(ov_s)})
    else $error("input voltage readback mismatch");
  power_code_a: assert property (rd_state
                                 |=> reg_rdata[2:0] == $past(pwr_s))
    else $error("power state code readback mismatch");
  bus_mask_read_a: assert property (rd_state
                                    |=> reg_rdata[`FIMS_BIT_BUS_ERROR] == $past(bus_err_mask_q))
    else $error("bus error mask readback mismatch");
  reserved_two_a: assert property (reg_rd_en && reg_addr == `FIMS_OFS_MASK_TWO
                                   |=> (reg_rdata & ~`FIMS_WMASK_TWO) == 8'h00)
    else $error("reserved bits of mask two read nonzero");
  unmapped_zero_a: assert property (reg_rd_en && reg_addr != `FIMS_OFS_MASK_ONE
                                    && reg_addr != `FIMS_OFS_MASK_TWO && reg_addr != `FIMS_OFS_MASK_STATE
                                    |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  write_one_a: assert property (wr_one
                                |=> mask_one_q == ($past(reg_wdata) & `FIMS_WMASK_ONE))
    else $error("write to mask one did not land");
  state_write_a: assert property (wr_state
                                  |=> mask_one_q == $past(mask_one_q) && mask_two_q == $past(mask_two_q))
    else $error("write to the live state register changed a mask register");
  rd_hold_a: assert property (!reg_rd_en
                              |=> $stable(reg_rdata))
    else $error("read data changed without a read strobe");
  conv_pend_hold_a: assert property (conv_pend_q && !rd_state
                                     |=> conv_pend_q)
    else $error("pending conversion ready event dropped without a status read");
  hiz_pend_hold_a: assert property (hiz_pend_q && !rd_state
                                    |=> hiz_pend_q)
    else $error("pending high impedance event dropped without a status read");
  berr_clear_a: assert property (rd_state && !serial_bus_error
                                 |=> !berr_pend_q)
    else $error("status read did not clear the pending bus error");
  all_masked_a: assert property (mask_one_q == `FIMS_WMASK_ONE && mask_two_q == `FIMS_WMASK_TWO
                                 && bus_err_mask_q |=> irq_n_q)
    else $error("interrupt low with every source masked");

endmodule : fims_top

// >>> tb/fims_top_tb.sv
// Self-checking bench for the fault interrupt mask and live state block.
`timescale 1ns/10ps

module fims_top_tb;
  // ==================================================================
  // Signals and row table
  typedef struct {logic [7:0] lvl; logic [2:0] ps; logic [7:0] m1; logic [7:0] m2; logic irq_n;} fims_row_s;
  logic clk, reset_n, reg_wr_en, reg_rd_en, serial_bus_error, fault_interrupt_out_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lvl;
  logic [2:0] power_state;
  logic [1:0] edg;
  int n_mismatch, n_compared;
  // Level bits: 0 under-V, 1 over-V, 2 aux rail, 3 thermal, 4 switch OC, 5 timer, 6 input_current_limited, 7 output_current_limited.
  fims_row_s rows [20] = '{
    '{8'h01, 3'h2, 8'h00, 8'h00, 1'b0}, '{8'h01, 3'h2, 8'h10, 8'h00, 1'b1},
    '{8'h02, 3'h2, 8'h03, 8'h00, 1'b0}, '{8'h02, 3'h2, 8'hFF, 8'h00, 1'b1},
    '{8'h04, 3'h2, 8'h00, 8'h00, 1'b0}, '{8'h04, 3'h2, 8'h02, 8'h00, 1'b1},
    '{8'h08, 3'h2, 8'h00, 8'h00, 1'b0}, '{8'h08, 3'h2, 8'h01, 8'h00, 1'b1},
    '{8'h10, 3'h2, 8'h00, 8'h00, 1'b0}, '{8'h10, 3'h2, 8'h00, 8'h80, 1'b1},
    '{8'h20, 3'h2, 8'h00, 8'hBC, 1'b0}, '{8'h20, 3'h2, 8'h00, 8'hFF, 1'b1},
    '{8'h00, 3'h3, 8'h00, 8'h00, 1'b0}, '{8'h00, 3'h3, 8'h00, 8'h20, 1'b1},
    '{8'h00, 3'h4, 8'h00, 8'h00, 1'b0}, '{8'h00, 3'h4, 8'h00, 8'h10, 1'b1},
    '{8'h40, 3'h1, 8'h00, 8'h00, 1'b1}, '{8'h80, 3'h0, 8'h00, 8'h00, 1'b1},
    '{8'h00, 3'h5, 8'h00, 8'h00, 1'b1}, '{8'h03, 3'h7, 8'h00, 8'h00, 1'b0}
  };

  fims_top i_fims_top (
    .clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .input_under_voltage(lvl[0]), .input_over_voltage(lvl[1]),
    .aux_regulator_rail_fault(lvl[2]), .thermal_shutdown(lvl[3]), .switch_overcurrent(lvl[4]),
    .timer_expired(lvl[5]), .conversion_ready(edg[0]), .high_impedance_state(edg[1]),
    .input_current_limited(lvl[6]), .output_current_limited(lvl[7]), .power_state(power_state),
    .serial_bus_error(serial_bus_error), .fault_interrupt_out_n(fault_interrupt_out_n)
  );

  // ==================================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic irq_is(input logic e);
    chk({7'h0, fault_interrupt_out_n}, {7'h0, e});
  endtask : irq_is

  // An idle cycle after each strobe keeps every strobe a single clean pulse.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    cyc(1);
    chk(reg_rdata, exp);
  endtask : rdchk

  task automatic bus_err_pulse();
    serial_bus_error = 1'b1;
    cyc(1);
    serial_bus_error = 1'b0;
    cyc(3);
  endtask : bus_err_pulse

  task automatic stop_test();
    $display("n_compared=%0d n_mismatch=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // ==================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #250000;
    n_mismatch++;
    stop_test();
  end

  // ==================================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lvl = 8'h00;
    edg = 2'h0;
    power_state = 3'h2;
    serial_bus_error = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    cyc(3);
    irq_is(1'b1);
    reset_n = 1'b1;
    cyc(3);
    rdchk(8'h1E, 8'h00);
    rdchk(8'h1F, 8'h00);
    rdchk(8'h20, 8'h02);
    wr(8'h21, 8'hFF);
    rdchk(8'h21, 8'h00);
    rdchk(8'h1E, 8'h00);
    foreach (rows[i]) begin
      wr(8'h1E, rows[i].m1);
      wr(8'h1F, rows[i].m2);
      lvl = rows[i].lvl;
      power_state = rows[i].ps;
      cyc(5);
      irq_is(rows[i].irq_n);
      rdchk(8'h1E, rows[i].m1 & 8'h13);
      rdchk(8'h1F, rows[i].m2 & 8'hFC);
      rdchk(8'h20, {1'b0, lvl[6], lvl[7], lvl[0], lvl[1], rows[i].ps});
      lvl = 8'h00;
      power_state = 3'h2;
      cyc(5);
      irq_is(1'b1);
    end
    wr(8'h1E, 8'h00);
    // Edge sources: pending until the state register is read, and held even while masked.
    for (int k = 0; k < 2; k++) begin
      wr(8'h1F, 8'h00);
      edg[k] = 1'b1;
      cyc(6);
      irq_is(1'b0);
      rdchk(8'h20, 8'h02);
      cyc(2);
      irq_is(1'b1);
      edg[k] = 1'b0;
      cyc(2);
      irq_is(1'b1);
      wr(8'h1F, 8'h08 >> k);
      edg[k] = 1'b1;
      cyc(2);
      edg[k] = 1'b0;
      cyc(5);
      irq_is(1'b1);
      wr(8'h1F, 8'h00);
      cyc(2);
      irq_is(1'b0);
      rdchk(8'h20, 8'h02);
      cyc(2);
      irq_is(1'b1);
    end
    bus_err_pulse();
    irq_is(1'b0);
    rdchk(8'h20, 8'h02);
    cyc(2);
    irq_is(1'b1);
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h82);
    bus_err_pulse();
    irq_is(1'b1);
    rdchk(8'h20, 8'h82);
    // A second reset in mid-run must drop the masks and release the pin at once.
    // Every source is masked first, so the under-voltage level must stay quiet.
    wr(8'h1E, 8'hFF);
    wr(8'h1F, 8'hFF);
    lvl = 8'h01;
    cyc(5);
    irq_is(1'b1);
    wr(8'h20, 8'h00);
    wr(8'h1E, 8'h00);
    cyc(3);
    irq_is(1'b0);
    reset_n = 1'b0;
    cyc(1);
    irq_is(1'b1);
    chk(reg_rdata, 8'h00);
    lvl = 8'h00;
    reset_n = 1'b1;
    cyc(3);
    rdchk(8'h20, 8'h02);
    irq_is(1'b1);
    stop_test();
  end
endmodule : fims_top_tb
